// ==== hdl/btc_cfg.svh ====
`ifndef BTC_CFG_SVH
`define BTC_CFG_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define BTC_IDX_CONTROL 10'h0A1
`define BTC_IDX_TUNING 10'h0A2
`define BTC_IDX_LOCK 10'h0A3
`define BTC_IDX_MISS_ACC 10'h0A4
`define BTC_IDX_FLASH_STAT 10'h0A5

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BTC_CTL_WREN 7
`define BTC_CTL_RDEN 6
`define BTC_CTL_PFEN 5
`define BTC_CTL_FLUSH 4
`define BTC_CTL_RETI 3
`define BTC_CTL_ISR 2
`define BTC_CTL_MOVC 1
`define BTC_CTL_BLKW 0
`define BTC_TN_ALGM 3
`define BTC_TN_FIXM 2
`define BTC_LC_PUSH 7
`define BTC_LC_POP 6
`define BTC_MA_OVF 7

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define BTC_RST_CONTROL 8'hE6
`define BTC_RST_TUNING 4'h4
`define BTC_RST_SLOT_PTR 6'h3E
`define BTC_RST_ACC 12'h000
`define BTC_RST_LFSR 8'hA5
`define BTC_SLOT_TOP 6'h3F
`define BTC_STALL_SAT 3'h7

`endif

// ==== hdl/btc_pkg.sv ====
package btc_pkg;
   typedef enum logic {BTC_APB_IDLE, BTC_APB_ANSWER} btc_apb_t;
   typedef logic [5:0] btc_slot_t;
endpackage

// ==== hdl/btc_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "btc_cfg.svh"


module btc_regs import btc_pkg::*; (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic miss_stall_in,
   input wire logic fill_ready_in,
   input wire logic fill_is_reti_in,
   input wire logic fill_is_isr_in,
   input wire logic fill_is_table_in,
   input wire logic table_read_in,
   input wire logic flash_busy_in,
   output logic cache_read_enable_out,
   output logic prefetch_enable_out,
   output logic fixed_rate_out,
   output logic flash_block_write_out,
   output logic cache_flush_out,
   output logic fill_write_out,
   output btc_slot_t fill_slot_out,
   output logic lock_write_out,
   output btc_slot_t lock_target_out,
   output btc_slot_t lock_slot_pointer_out,
   output logic all_unlocked_out
);

   function automatic logic btc_hit(input logic [11:0] addr, input logic [9:0] idx);
      btc_hit = (addr[11:2] == idx) && (addr[1:0] == 2'b00);
   endfunction

   // ----------------------------------------------------------------
   // apb slave: zero wait states, answer registered at setup
   // ----------------------------------------------------------------
   btc_apb_t apb_r, apb_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pslverr_r, pslverr_nxt;
   logic setup, wr_go, mapped;
   logic [7:0] rd_byte;
   logic [7:0] ctl_r, ctl_nxt;
   logic [3:0] tune_r, tune_nxt;
   logic [3:0] nib_r, nib_nxt;
   logic push_en_r, push_en_nxt;
   btc_slot_t slot_ptr_r, slot_ptr_nxt;
   logic [11:0] acc_r, acc_nxt;
   logic ovf_r, ovf_nxt;

   assign setup = psel_in && !penable_in;
   assign wr_go = psel_in && penable_in && pwrite_in && (apb_r == BTC_APB_ANSWER);
   assign mapped = btc_hit(paddr_in, `BTC_IDX_CONTROL) || btc_hit(paddr_in, `BTC_IDX_TUNING)
      || btc_hit(paddr_in, `BTC_IDX_LOCK) || btc_hit(paddr_in, `BTC_IDX_MISS_ACC)
      || btc_hit(paddr_in, `BTC_IDX_FLASH_STAT);

   always_comb begin
      rd_byte = 8'h00;
      if (btc_hit(paddr_in, `BTC_IDX_CONTROL)) begin
         rd_byte = ctl_r & 8'hEF;
      end else if (btc_hit(paddr_in, `BTC_IDX_TUNING)) begin
         rd_byte = {nib_r, tune_r};
      end else if (btc_hit(paddr_in, `BTC_IDX_LOCK)) begin
         rd_byte = {push_en_r, 1'b0, slot_ptr_r};
      end else if (btc_hit(paddr_in, `BTC_IDX_MISS_ACC)) begin
         rd_byte = {ovf_r, acc_r[11:5]};
      end else if (btc_hit(paddr_in, `BTC_IDX_FLASH_STAT)) begin
         rd_byte = {7'h00, flash_busy_in};
      end
   end

   always_comb begin
      apb_nxt = BTC_APB_IDLE;
      prdata_nxt = prdata_r;
      pslverr_nxt = 1'b0;
      if (setup) begin
         apb_nxt = BTC_APB_ANSWER;
         prdata_nxt = pwrite_in ? 32'h0000_0000 : {24'h00_0000, rd_byte};
         pslverr_nxt = !mapped;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         apb_r <= BTC_APB_IDLE;
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else begin
         apb_r <= apb_nxt;
         prdata_r <= prdata_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   assign prdata_out = prdata_r;
   assign pready_out = (apb_r == BTC_APB_ANSWER);
   assign pslverr_out = pslverr_r;

   // ----------------------------------------------------------------
   // control, tuning and lock stack
   // ----------------------------------------------------------------
   logic flush_r, flush_nxt;
   logic pop_go, push_go;
   logic unlocked_r, unlocked_nxt;

   assign pop_go = wr_go && btc_hit(paddr_in, `BTC_IDX_LOCK) && pwdata_in[`BTC_LC_POP];
   assign push_go = table_read_in && push_en_r;

   always_comb begin
      ctl_nxt = ctl_r;
      tune_nxt = tune_r;
      push_en_nxt = push_en_r;
      flush_nxt = 1'b0;
      slot_ptr_nxt = slot_ptr_r;
      if (wr_go && btc_hit(paddr_in, `BTC_IDX_CONTROL)) begin
         ctl_nxt = pwdata_in[7:0] & 8'hEF;
         flush_nxt = pwdata_in[`BTC_CTL_FLUSH];
      end
      if (wr_go && btc_hit(paddr_in, `BTC_IDX_TUNING)) begin
         tune_nxt = pwdata_in[3:0];
      end
      if (wr_go && btc_hit(paddr_in, `BTC_IDX_LOCK)) begin
         push_en_nxt = pwdata_in[`BTC_LC_PUSH];
      end
      // pointer is never written by software, only pushed and popped
      if (pop_go && !push_go) begin
         slot_ptr_nxt = slot_ptr_r + 6'h01;
      end else if (push_go && !pop_go) begin
         slot_ptr_nxt = slot_ptr_r - 6'h01;
      end
      unlocked_nxt = (slot_ptr_nxt == 6'h00);
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctl_r <= `BTC_RST_CONTROL;
         tune_r <= `BTC_RST_TUNING;
         push_en_r <= 1'b0;
         flush_r <= 1'b0;
         slot_ptr_r <= `BTC_RST_SLOT_PTR;
         unlocked_r <= 1'b0;
      end else begin
         ctl_r <= ctl_nxt;
         tune_r <= tune_nxt;
         push_en_r <= push_en_nxt;
         flush_r <= flush_nxt;
         slot_ptr_r <= slot_ptr_nxt;
         unlocked_r <= unlocked_nxt;
      end
   end

   // ----------------------------------------------------------------
   // miss penalty accumulator
   // ----------------------------------------------------------------
   logic acc_wr, acc_rd;
   logic [12:0] acc_inc;

   assign acc_wr = wr_go && btc_hit(paddr_in, `BTC_IDX_MISS_ACC);
   // latch at setup so the nibble matches the high field just sampled
   assign acc_rd = setup && !pwrite_in && btc_hit(paddr_in, `BTC_IDX_MISS_ACC);
   assign acc_inc = {1'b0, acc_r} + 13'h0001;

   always_comb begin
      acc_nxt = acc_r;
      ovf_nxt = ovf_r;
      nib_nxt = nib_r;
      if (acc_wr) begin
         acc_nxt = {pwdata_in[6:0], 5'h00};
         ovf_nxt = 1'b0;
      end else if (miss_stall_in) begin
         acc_nxt = acc_inc[11:0];
         if (acc_inc[12]) begin
            ovf_nxt = 1'b1;
         end
      end
      if (acc_rd) begin
         nib_nxt = acc_r[4:1];
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         acc_r <= `BTC_RST_ACC;
         ovf_r <= 1'b0;
         nib_r <= 4'h0;
      end else begin
         acc_r <= acc_nxt;
         ovf_r <= ovf_nxt;
         nib_r <= nib_nxt;
      end
   end

   // ----------------------------------------------------------------
   // fill decision and slot choice
   // ----------------------------------------------------------------
   logic [2:0] stall_cnt_r, stall_cnt_nxt;
   logic [3:0] pen_now;
   logic pen_ok, fill_ok, fix_slot;
   btc_slot_t limit, victim;
   logic fill_wr_r, fill_wr_nxt;
   btc_slot_t fill_slot_r, fill_slot_nxt;
   logic lock_wr_r, lock_wr_nxt;
   btc_slot_t lock_tgt_r, lock_tgt_nxt;
   logic fixed_r, fixed_nxt;

   assign pen_now = {1'b0, stall_cnt_r} + {3'h0, miss_stall_in};
   assign pen_ok = pen_now > {2'b00, tune_r[1:0]};
   // pointer zero opens the whole cache, so software stops at 61 locks
   assign limit = (slot_ptr_r == 6'h00) ? `BTC_SLOT_TOP : slot_ptr_r;
   assign fix_slot = fill_is_table_in && tune_r[`BTC_TN_FIXM];
   assign fill_ok = fill_ready_in && ctl_r[`BTC_CTL_WREN] && pen_ok
      && (!fill_is_reti_in || ctl_r[`BTC_CTL_RETI])
      && (!fill_is_isr_in || ctl_r[`BTC_CTL_ISR])
      && (!fill_is_table_in || (ctl_r[`BTC_CTL_MOVC] && !push_en_r));

   btc_slot_pick u_pick (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .advance_in(fill_ok && !fix_slot),
      .random_in(tune_r[`BTC_TN_ALGM]),
      .limit_in(limit),
      .slot_out(victim)
   );

   always_comb begin
      stall_cnt_nxt = stall_cnt_r;
      if (fill_ready_in) begin
         stall_cnt_nxt = 3'h0;
      end else if (miss_stall_in && stall_cnt_r != `BTC_STALL_SAT) begin
         stall_cnt_nxt = stall_cnt_r + 3'h1;
      end
      fill_wr_nxt = fill_ok;
      // a push can drop the limit under the walker for one cycle
      fill_slot_nxt = fix_slot ? 6'h00 : ((victim > limit) ? limit : victim);
      lock_wr_nxt = push_go;
      lock_tgt_nxt = slot_ptr_r;
      fixed_nxt = !ctl_r[`BTC_CTL_RDEN] && !ctl_r[`BTC_CTL_PFEN];
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stall_cnt_r <= 3'h0;
         fill_wr_r <= 1'b0;
         fill_slot_r <= 6'h00;
         lock_wr_r <= 1'b0;
         lock_tgt_r <= 6'h00;
         fixed_r <= 1'b0;
      end else begin
         stall_cnt_r <= stall_cnt_nxt;
         fill_wr_r <= fill_wr_nxt;
         fill_slot_r <= fill_slot_nxt;
         lock_wr_r <= lock_wr_nxt;
         lock_tgt_r <= lock_tgt_nxt;
         fixed_r <= fixed_nxt;
      end
   end

   assign cache_read_enable_out = ctl_r[`BTC_CTL_RDEN];
   assign prefetch_enable_out = ctl_r[`BTC_CTL_PFEN];
   assign flash_block_write_out = ctl_r[`BTC_CTL_BLKW];
   assign fixed_rate_out = fixed_r;
   assign cache_flush_out = flush_r;
   assign fill_write_out = fill_wr_r;
   assign fill_slot_out = fill_slot_r;
   assign lock_write_out = lock_wr_r;
   assign lock_target_out = lock_tgt_r;
   assign lock_slot_pointer_out = slot_ptr_r;
   assign all_unlocked_out = unlocked_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_flush_pulse;
      cache_flush_out ##1 !cache_flush_out;
   endsequence
   property p_flush;
      wr_go && btc_hit(paddr_in, `BTC_IDX_CONTROL) && pwdata_in[4] |=> s_flush_pulse;
   endproperty
   a_flush: assert property (p_flush) else $error("flush pulse missing");
   property p_wren;
      fill_write_out |-> $past(ctl_r[7]);
   endproperty
   a_wren: assert property (p_wren) else $error("fill with writes off");
   property p_rden;
      wr_go && btc_hit(paddr_in, `BTC_IDX_CONTROL) |=> cache_read_enable_out == $past(pwdata_in[6]);
   endproperty
   a_rden: assert property (p_rden) else $error("read enable not loaded");
   property p_fixed;
      fixed_rate_out |-> !$past(ctl_r[6]) && !$past(ctl_r[5]);
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed rate wrong");
   property p_reti;
      fill_ready_in && fill_is_reti_in && !ctl_r[3] |=> !fill_write_out;
   endproperty
   a_reti: assert property (p_reti) else $error("reti target cached");
   property p_fix_slot;
      fill_write_out && $past(fix_slot) |-> fill_slot_out == 6'h00;
   endproperty
   a_fix_slot: assert property (p_fix_slot) else $error("table data not in slot 0");
   property p_thresh;
      fill_write_out |-> $past(pen_ok);
   endproperty
   a_thresh: assert property (p_thresh) else $error("fill below threshold");
   sequence s_push_done;
      lock_write_out && lock_target_out == $past(slot_ptr_r);
   endsequence
   property p_push;
      push_go && !pop_go |=> s_push_done ##0 slot_ptr_r == $past(slot_ptr_r) - 6'h01;
   endproperty
   a_push: assert property (p_push) else $error("push did not lock");
   property p_pop;
      pop_go && !push_go |=> slot_ptr_r == $past(slot_ptr_r) + 6'h01;
   endproperty
   a_pop: assert property (p_pop) else $error("pop did not increment");
   property p_locked;
      fill_write_out && $past(slot_ptr_r) != 6'h00 |-> fill_slot_out <= $past(slot_ptr_r);
   endproperty
   a_locked: assert property (p_locked) else $error("locked slot replaced");
   property p_ovf;
      acc_r == 12'hFFF && miss_stall_in && !acc_wr |=> ovf_r && acc_r == 12'h000;
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow not flagged");
   property p_count;
      miss_stall_in && !acc_wr && acc_r != 12'hFFF |=> acc_r == $past(acc_r) + 12'h001;
   endproperty
   a_count: assert property (p_count) else $error("stall not counted");
   property p_acc_wr;
      acc_wr |=> acc_r == {$past(pwdata_in[6:0]), 5'h00} && !ovf_r;
   endproperty
   a_acc_wr: assert property (p_acc_wr) else $error("high write wrong");
   property p_latch;
      acc_rd |=> nib_r == $past(acc_r[4:1]);
   endproperty
   a_latch: assert property (p_latch) else $error("nibble not latched");
   property p_busy;
      setup && !pwrite_in && btc_hit(paddr_in, `BTC_IDX_FLASH_STAT)
         |=> prdata_out[0] == $past(flash_busy_in);
   endproperty
   a_busy: assert property (p_busy) else $error("busy bit wrong");

endmodule
`default_nettype wire

// ==== hdl/btc_slot_pick.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "btc_cfg.svh"

module btc_slot_pick import btc_pkg::*; (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic advance_in,
   input wire logic random_in,
   input wire btc_slot_t limit_in,
   output btc_slot_t slot_out
);

   // ----------------------------------------------------------------
   // victim slot: rebound walk or pseudo-random, above limit for one cycle at most
   // ----------------------------------------------------------------
   btc_slot_t slot_r, slot_nxt;
   logic up_r, up_nxt;
   logic [7:0] lfsr_r, lfsr_nxt;

   always_comb begin
      slot_nxt = slot_r;
      up_nxt = up_r;
      lfsr_nxt = {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
      if (advance_in) begin
         if (random_in) begin
            // masking keeps the pick inside the unlocked range
            slot_nxt = (lfsr_r[5:0] <= limit_in) ? lfsr_r[5:0] : (lfsr_r[5:0] & limit_in);
         end else if (slot_r >= limit_in) begin
            up_nxt = 1'b0;
            slot_nxt = (limit_in == 6'h00) ? 6'h00 : limit_in - 6'h01;
         end else if (up_r || slot_r == 6'h00) begin
            up_nxt = 1'b1;
            slot_nxt = slot_r + 6'h01;
         end else begin
            slot_nxt = slot_r - 6'h01;
         end
      end else if (slot_r > limit_in) begin
         slot_nxt = limit_in;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         slot_r <= 6'h00;
         up_r <= 1'b1;
         lfsr_r <= `BTC_RST_LFSR;
      end else begin
         slot_r <= slot_nxt;
         up_r <= up_nxt;
         lfsr_r <= lfsr_nxt;
      end
   end

   assign slot_out = slot_r;

   property p_rebound_step;
      @(posedge clock_in) disable iff (!rst_n_in)
      advance_in && !random_in && up_r && slot_r < limit_in |=> slot_r == $past(slot_r) + 6'h01;
   endproperty
   a_rebound_step: assert property (p_rebound_step) else $error("rebound step wrong");

endmodule
`default_nettype wire

// ==== verification/btc_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// core fetch side and flash controller, driven on rising edges
// ----------------------------------------------------------------
module btc_core_model (
   input wire logic clock_in,
   output logic miss_stall_out,
   output logic fill_ready_out,
   output logic fill_is_reti_out,
   output logic fill_is_isr_out,
   output logic fill_is_table_out,
   output logic table_read_out,
   output logic flash_busy_out
);
   initial begin
      miss_stall_out = 1'h0;
      fill_ready_out = 1'h0;
      fill_is_reti_out = 1'h0;
      fill_is_isr_out = 1'h0;
      fill_is_table_out = 1'h0;
      table_read_out = 1'h0;
      flash_busy_out = 1'h0;
   end

   // n stalled cycles, the word arrives in the last one
   task automatic miss(input int n, input logic reti, input logic isr, input logic tbl);
      for (int i = 1; i <= n; i++) begin
         @(posedge clock_in);
         miss_stall_out <= 1'h1;
         fill_ready_out <= (i == n);
         fill_is_reti_out <= reti & (i == n);
         fill_is_isr_out <= isr & (i == n);
         fill_is_table_out <= tbl & (i == n);
      end
      @(posedge clock_in);
      miss_stall_out <= 1'h0;
      fill_ready_out <= 1'h0;
      fill_is_reti_out <= 1'h0;
      fill_is_isr_out <= 1'h0;
      fill_is_table_out <= 1'h0;
   endtask

   task automatic table_read();
      @(posedge clock_in);
      table_read_out <= 1'h1;
      @(posedge clock_in);
      table_read_out <= 1'h0;
   endtask

   task automatic set_busy(input logic b);
      @(posedge clock_in);
      flash_busy_out <= b;
   endtask
endmodule
`default_nettype wire

// ==== verification/test_btc_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "btc_cfg.svh"

module test_btc_regs import btc_pkg::*; ;
   logic clock_in = 1'h0;
   logic rst_n = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, stall, fready, freti, fisr, ftbl, trd, fbusy;
   wire logic rd_en, pf_en, fixed, blkw, flush, fill_wr, lock_wr, unlocked;
   wire btc_slot_t fill_slot, lock_target, slot_ptr;
   int num_errors = 0;
   int checked = 0;
   int fills = 0;
   int flushes = 0;
   int locks = 0;
   btc_slot_t last_slot, last_target;
   logic [7:0] d;
   logic e;

   btc_regs dut (.clock_in(clock_in), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .miss_stall_in(stall),
      .fill_ready_in(fready), .fill_is_reti_in(freti), .fill_is_isr_in(fisr),
      .fill_is_table_in(ftbl), .table_read_in(trd), .flash_busy_in(fbusy),
      .cache_read_enable_out(rd_en), .prefetch_enable_out(pf_en), .fixed_rate_out(fixed),
      .flash_block_write_out(blkw), .cache_flush_out(flush), .fill_write_out(fill_wr),
      .fill_slot_out(fill_slot), .lock_write_out(lock_wr), .lock_target_out(lock_target),
      .lock_slot_pointer_out(slot_ptr), .all_unlocked_out(unlocked));

   btc_core_model core (.clock_in(clock_in), .miss_stall_out(stall), .fill_ready_out(fready),
      .fill_is_reti_out(freti), .fill_is_isr_out(fisr), .fill_is_table_out(ftbl),
      .table_read_out(trd), .flash_busy_out(fbusy));

   always #20 clock_in = ~clock_in;

   // pulse outputs are counted so a doubled or missing pulse shows
   always @(posedge clock_in) begin
      if (fill_wr === 1'h1) begin
         fills++;
         last_slot = fill_slot;
      end
      if (lock_wr === 1'h1) begin
         locks++;
         last_target = lock_target;
      end
      if (flush === 1'h1) begin
         flushes++;
      end
   end

   // ----------------------------------------------------------------
   // bus and compare helpers
   // ----------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge clock_in);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= {idx, 2'h0};
      pwdata <= {24'h0, wd};
      @(posedge clock_in);
      penable <= 1'h1;
      do begin
         @(posedge clock_in);
         n++;
      end while (pready !== 1'h1 && n < 20);
      chk("pready", 1'h1, pready);
      d = prdata[7:0];
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic rc(input string name, input logic [9:0] idx, input logic [7:0] exp);
      apb(1'h0, idx, 8'h00);
      chk(name, exp, d);
      chk({name, " err"}, 1'h0, e);
   endtask

   task automatic wait2();
      repeat (2) @(posedge clock_in);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      rc("control", `BTC_IDX_CONTROL, 8'hE6);
      rc("tuning", `BTC_IDX_TUNING, 8'h04);
      rc("lock", `BTC_IDX_LOCK, 8'h3E);
      rc("miss acc", `BTC_IDX_MISS_ACC, 8'h00);
      rc("flash stat", `BTC_IDX_FLASH_STAT, 8'h00);
      apb(1'h0, 10'h0A6, 8'h00);
      chk("unmapped data", 8'h00, d);
      chk("unmapped err", 1'h1, e);
      chk("outs", 4'hC, {rd_en, pf_en, fixed, unlocked});
      $display("test reset done");
   endtask

   task automatic t_accum();
      apb(1'h1, `BTC_IDX_MISS_ACC, 8'h05);
      core.miss(6, 1'h0, 1'h0, 1'h0);
      rc("nibble before latch", `BTC_IDX_TUNING, 8'h04);
      rc("acc high", `BTC_IDX_MISS_ACC, 8'h05);
      rc("nibble latched", `BTC_IDX_TUNING, 8'h34);
      apb(1'h1, `BTC_IDX_MISS_ACC, 8'h7F);
      core.miss(32, 1'h0, 1'h0, 1'h0);
      rc("overflow", `BTC_IDX_MISS_ACC, 8'h80);
      apb(1'h1, `BTC_IDX_MISS_ACC, 8'h00);
      rc("overflow cleared", `BTC_IDX_MISS_ACC, 8'h00);
      $display("test accumulator done");
   endtask

   task automatic t_fill();
      logic [7:0] ctl [5] = '{8'h66, 8'hE6, 8'hEE, 8'hE2, 8'hE2};
      logic [4:0] reti = 5'b00110;
      logic [4:0] isr = 5'b11001;
      logic [4:0] take = 5'b01100;
      int f0;
      apb(1'h1, `BTC_IDX_TUNING, 8'h02);
      f0 = fills;
      core.miss(2, 1'h0, 1'h0, 1'h0);
      wait2();
      chk("fill at threshold", f0, fills);
      core.miss(3, 1'h0, 1'h0, 1'h0);
      wait2();
      chk("fill above threshold", f0 + 1, fills);
      chk("rebound third slot", 6'h02, last_slot);
      for (int i = 0; i < 5; i++) begin
         apb(1'h1, `BTC_IDX_CONTROL, ctl[i]);
         f0 = fills;
         core.miss(3, reti[4 - i], isr[4 - i], 1'h0);
         wait2();
         chk("fill gate", f0 + take[4 - i], fills);
      end
      apb(1'h1, `BTC_IDX_TUNING, 8'h08);
      f0 = fills;
      core.miss(1, 1'h0, 1'h0, 1'h0);
      wait2();
      chk("random fill", f0 + 1, fills);
      apb(1'h1, `BTC_IDX_TUNING, 8'h04);
      f0 = fills;
      core.miss(1, 1'h0, 1'h0, 1'h1);
      wait2();
      chk("table fill", f0 + 1, fills);
      chk("table slot", 6'h00, last_slot);
      $display("test fill done");
   endtask

   task automatic t_control();
      int f0;
      f0 = flushes;
      apb(1'h1, `BTC_IDX_CONTROL, 8'h91);
      wait2();
      chk("flush pulses", f0 + 1, flushes);
      rc("flush reads zero", `BTC_IDX_CONTROL, 8'h81);
      chk("rd pf fixed blkw", 4'h3, {rd_en, pf_en, fixed, blkw});
      apb(1'h1, `BTC_IDX_CONTROL, 8'hA0);
      wait2();
      chk("rd pf fixed blkw", 4'h4, {rd_en, pf_en, fixed, blkw});
      apb(1'h1, `BTC_IDX_CONTROL, 8'hE6);
      $display("test control done");
   endtask

   task automatic t_lock();
      int l0;
      l0 = locks;
      apb(1'h1, `BTC_IDX_LOCK, 8'h80);
      core.table_read();
      wait2();
      chk("push", l0 + 1, locks);
      chk("push target", 6'h3E, last_target);
      rc("after push", `BTC_IDX_LOCK, 8'hBD);
      apb(1'h1, `BTC_IDX_LOCK, 8'h40);
      rc("after pop", `BTC_IDX_LOCK, 8'h3E);
      core.table_read();
      wait2();
      chk("push disabled", l0 + 1, locks);
      apb(1'h1, `BTC_IDX_LOCK, 8'h05);
      rc("pointer read only", `BTC_IDX_LOCK, 8'h3E);
      // reaching zero takes one push past the lockable limit
      apb(1'h1, `BTC_IDX_LOCK, 8'h80);
      repeat (62) core.table_read();
      wait2();
      chk("pointer zero", 7'h40, {unlocked, slot_ptr});
      core.set_busy(1'h1);
      rc("flash busy", `BTC_IDX_FLASH_STAT, 8'h01);
      core.set_busy(1'h0);
      rc("flash idle", `BTC_IDX_FLASH_STAT, 8'h00);
      $display("test lock and flash done");
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge clock_in);
      rst_n <= 1'h1;
      t_reset();
      t_accum();
      t_fill();
      t_control();
      t_lock();
      print_verdict();
   end

   initial begin
      #(40 * 20000);
      num_errors++;
      print_verdict();
   end
endmodule
`default_nettype wire
